// *** ibr_requester.sv ***
// in-band interrupt requester: APB registers, event gating and SDA engine
`default_nettype none
`include "ibr_consts.svh"
//Contract
// - no interrupt request while in I2C mode
// - all interrupt enables read zero after reset
// - enabled error event sets pending and requests
// - disabled error event still sets pending nibble
// - enabled temperature event sets pending and requests
// - master off: no request, pending still set
// - after START send address, read bit
// - idle bus: pull SDA low, then address
// - on ACK send MDB, temperature, error bytes
// - packet check enabled appends check byte
// - host abort at T keeps pending state
// - full payload clears pending flag and nibble
// - NACK: no payload, pending kept, retry later
// - check byte is CRC-8 0x07, zero seed
// - status bits latched until host writes one
// - lost arbitration releases SDA, waits
module ibr_requester import ibr_pkg::*; #(
  parameter logic [3:0] LCODE_DEFAULT = 4'h3,
  parameter logic [2:0] HCODE_DEFAULT = 3'h7
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] temp_event,
  input wire logic [1:0] error_event,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  localparam int AVAL_CYC =
    (`IBR_AVAL_NS + `IBR_LINK_PERIOD_NS - 1) / `IBR_LINK_PERIOD_NS;
  localparam int ISSUE_RAW = `IBR_ISSUE_NS / `IBR_LINK_PERIOD_NS;
  localparam int ISSUE_CYC = (ISSUE_RAW < 1) ? 1 : ISSUE_RAW;

  function automatic logic [7:0] ibr_crc8(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `IBR_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  ibr_core_t q, next_q;
  ibr_link_t l, next_l;
  logic [2:0] lrst_s;
  logic lrst;
  logic [3:0] tclr, trise;
  logic [1:0] eclr, erise;
  logic [3:0] tstat_n;
  logic [1:0] estat_n;
  logic wr, clr_any, done_evt;

  assign lrst = lrst_s[2];
  assign done_evt = q.done_s[2] ^ q.done_s[1];

  // core domain: APB slave, latched status, pending flag and request level
  always_comb begin
    next_q = q;
    tclr = 4'h0;
    eclr = 2'h0;
    wr = psel && penable && !q.pready && pwrite;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    next_q.busy_s = {q.busy_s[0], l.busy};
    next_q.done_s = {q.done_s[1:0], l.done_tgl};
    if (psel && penable && !q.pready) begin
      next_q.pready = 1'b1;
      next_q.prdata = 32'h0;
      if (paddr == `IBR_REG_ENABLE) begin
        next_q.prdata[4:0] = q.ien;
        if (wr) next_q.ien = pwdata[4:0];
      end else if (paddr == `IBR_REG_PENDING) begin
        next_q.prdata[`IBR_PEND_FLAG] = q.pending;
        next_q.prdata[3:0] = q.nibble;
      end else if (paddr == `IBR_REG_TEMP) begin
        next_q.prdata[3:0] = q.tstat;
        if (wr) tclr = pwdata[3:0];
      end else if (paddr == `IBR_REG_ERROR) begin
        next_q.prdata[1:0] = q.estat;
        if (wr) eclr = pwdata[1:0];
      end else if (paddr == `IBR_REG_CTRL) begin
        next_q.prdata[`IBR_CTRL_I3C] = q.i3c;
        next_q.prdata[`IBR_CTRL_PEC] = q.packet_check_byte;
        next_q.prdata[`IBR_CTRL_LCODE_LSB +: 4] = q.lcode;
        next_q.prdata[`IBR_CTRL_HCODE_LSB +: 3] = q.hcode;
        if (wr) begin
          next_q.i3c = pwdata[`IBR_CTRL_I3C];
          next_q.packet_check_byte = pwdata[`IBR_CTRL_PEC];
          next_q.lcode = pwdata[`IBR_CTRL_LCODE_LSB +: 4];
          next_q.hcode = pwdata[`IBR_CTRL_HCODE_LSB +: 3];
          if (pwdata[`IBR_CTRL_GCLR]) begin
            tclr = 4'hf;
            eclr = 2'h3;
          end
        end
      end else begin
        next_q.pslverr = 1'b1;
      end
    end
    // a condition still present sets its bit again, so set beats clear
    tstat_n = (q.tstat & ~tclr) | temp_event;
    estat_n = (q.estat & ~eclr) | error_event;
    next_q.tstat = tstat_n;
    next_q.estat = estat_n;
    clr_any = (|tclr) || (|eclr);
    trise = tstat_n & ~q.tstat & q.ien[3:0];
    erise = estat_n & ~q.estat;
    if (done_evt) begin
      next_q.pending = 1'b0;
      next_q.nibble = `IBR_NIB_NONE;
    end
    if (clr_any && tstat_n == 4'h0 && estat_n == 2'h0) begin
      next_q.pending = 1'b0;
      next_q.nibble = `IBR_NIB_NONE;
    end
    // pending is set regardless of the master enable
    if ((|trise) || (|erise)) begin
      next_q.pending = 1'b1;
      next_q.nibble = `IBR_NIB_EVENT;
    end
    // the bus is asked only with master enable set and in I3C mode
    next_q.req = next_q.pending && next_q.ien[`IBR_EN_MASTER]
                 && next_q.i3c;
    // payload bytes frozen while the link is busy, so they cross stable
    if (!q.busy_s[1]) begin
      next_q.snap_temp = {4'h0, q.tstat};
      next_q.snap_err = {6'h0, q.estat};
      next_q.snap_pec = q.packet_check_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.ien <= `IBR_EN_RESET;
      q.lcode <= LCODE_DEFAULT;
      q.hcode <= HCODE_DEFAULT;
      q.nibble <= `IBR_NIB_NONE;
    end else begin
      q <= next_q;
    end
  end

  // reset into the link domain through a three-stage synchroniser
  always_ff @(posedge link_clk) begin
    lrst_s <= {lrst_s[1:0], srst};
  end

  logic scl_nf, sda_nf, scl_fall, scl_rise, start_c, stop_c, avail;
  logic [7:0] first_byte;
  logic [1:0] last_idx;

  // link domain: filtered bus lines, START/STOP, idle timer, bit engine
  always_comb begin
    next_l = l;
    next_l.scl_s = {l.scl_s[1:0], scl};
    next_l.sda_s = {l.sda_s[1:0], sda_in};
    scl_nf = (l.scl_s[2] == l.scl_s[1]) ? l.scl_s[2] : l.scl_f;
    sda_nf = (l.sda_s[2] == l.sda_s[1]) ? l.sda_s[2] : l.sda_f;
    next_l.scl_f = scl_nf;
    next_l.sda_f = sda_nf;
    next_l.req_s = {l.req_s[0], q.req};
    scl_fall = l.scl_f && !scl_nf;
    scl_rise = !l.scl_f && scl_nf;
    start_c = l.sda_f && !sda_nf && scl_nf && l.scl_f;
    stop_c = !l.sda_f && sda_nf && scl_nf && l.scl_f;
    if ((scl_nf != l.scl_f) || (sda_nf != l.sda_f)) begin
      next_l.idle_cnt = 16'h0;
    end else if (l.idle_cnt != 16'(AVAL_CYC)) begin
      next_l.idle_cnt = l.idle_cnt + 16'h1;
    end
    avail = (l.idle_cnt == 16'(AVAL_CYC)) && l.scl_f && l.sda_f;
    first_byte = {q.lcode, q.hcode, 1'b1};
    last_idx = q.snap_pec ? 2'd3 : 2'd2;
    case (l.state)
      L_IDLE: begin
        next_l.sda_oe = 1'b0;
        next_l.busy = 1'b0;
        next_l.shreg = first_byte;
        next_l.crc = ibr_crc8(`IBR_CRC_SEED, first_byte);
        next_l.bitcnt = 3'd0;
        if (l.req_s[1] && start_c) begin
          next_l.state = L_WSTART;
          next_l.busy = 1'b1;
        end else if (l.req_s[1] && avail) begin
          next_l.state = L_REQ;
          next_l.busy = 1'b1;
          next_l.sda_oe = 1'b1;
          next_l.sda_out = 1'b0;
        end
      end
      L_REQ, L_WSTART: begin
        // host answers the low SDA by clocking SCL
        if (scl_fall) begin
          next_l.state = L_ADDR;
          next_l.sda_out = 1'b0;
          next_l.sda_oe = !l.shreg[7];
        end
      end
      L_ADDR: begin
        if (scl_rise && l.shreg[7] && !sda_nf) begin
          next_l.state = L_WSTOP;
          next_l.sda_oe = 1'b0;
        end else if (scl_fall) begin
          if (l.bitcnt == 3'd7) begin
            next_l.state = L_ACK;
            next_l.sda_oe = 1'b0;
          end else begin
            next_l.shreg = {l.shreg[6:0], 1'b0};
            next_l.bitcnt = l.bitcnt + 3'd1;
            next_l.sda_oe = !l.shreg[6];
          end
        end
      end
      L_ACK: begin
        if (scl_rise) begin
          if (!sda_nf) begin
            next_l.state = L_PUSH;
            next_l.byte_idx = 2'd0;
            next_l.shreg = `IBR_MDB;
            next_l.crc = ibr_crc8(l.crc, `IBR_MDB);
          end else begin
            next_l.state = L_WSTOP;
          end
        end
      end
      L_PUSH: begin
        if (scl_fall) begin
          next_l.state = L_DATA;
          next_l.bitcnt = 3'd0;
          next_l.sda_oe = 1'b1;
          next_l.sda_out = l.shreg[7];
        end
      end
      L_DATA: begin
        if (scl_fall) begin
          if (l.bitcnt == 3'd7) begin
            // T=0 on the last byte is driven; T=1 released for host abort
            next_l.state = L_TBIT;
            next_l.sda_out = 1'b0;
            next_l.sda_oe = (l.byte_idx == last_idx);
          end else begin
            next_l.shreg = {l.shreg[6:0], 1'b0};
            next_l.bitcnt = l.bitcnt + 3'd1;
            next_l.sda_out = l.shreg[6];
          end
        end
      end
      L_TBIT: begin
        if (scl_rise) begin
          if (l.byte_idx == last_idx) begin
            next_l.done_tgl = !l.done_tgl;
            next_l.state = L_WSTOP;
            next_l.sda_oe = 1'b0;
          end else if (!sda_nf) begin
            next_l.state = L_WSTOP;
          end else begin
            next_l.state = L_PUSH;
            next_l.byte_idx = l.byte_idx + 2'd1;
            if (l.byte_idx == 2'd0) begin
              next_l.shreg = q.snap_temp;
              next_l.crc = ibr_crc8(l.crc, q.snap_temp);
            end else if (l.byte_idx == 2'd1) begin
              next_l.shreg = q.snap_err;
              next_l.crc = ibr_crc8(l.crc, q.snap_err);
            end else begin
              next_l.shreg = l.crc;
            end
          end
        end
      end
      L_WSTOP: begin
        next_l.sda_oe = 1'b0;
        if (stop_c || start_c) next_l.state = L_IDLE;
      end
      default: next_l.state = L_IDLE;
    endcase
    // a STOP mid-transfer aborts without reporting completion
    if (stop_c && l.state != L_IDLE && l.state != L_WSTOP) begin
      next_l.state = L_IDLE;
      next_l.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      l <= '0;
      l.scl_s <= 3'h7;
      l.sda_s <= 3'h7;
      l.scl_f <= 1'b1;
      l.sda_f <= 1'b1;
      l.state <= L_IDLE;
      l.sda_out <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign sda_out = l.sda_out;
  assign sda_oe = l.sda_oe;

  // checks in the core domain
  sequence s_err_rise;
    (error_event != 2'h0) && (q.estat == 2'h0);
  endsequence
  sequence s_pend_set;
    q.pending && (q.nibble == `IBR_NIB_EVENT);
  endsequence
  a_req_mode_gate: assert property (@(posedge core_clk) disable iff (srst)
    q.req |-> q.i3c && q.ien[`IBR_EN_MASTER])
    else $error("request raised without I3C mode or master enable");
  a_enable_reset: assert property (@(posedge core_clk)
    $past(srst) && !srst |-> q.ien == 5'h00)
    else $error("interrupt enables not zero after reset");
  a_err_pending: assert property (@(posedge core_clk) disable iff (srst)
    s_err_rise |=> s_pend_set)
    else $error("error event did not set pending nibble");
  a_err_no_enable: assert property (@(posedge core_clk) disable iff (srst)
    s_err_rise ##0 !q.ien[`IBR_EN_MASTER] ##1 !q.ien[`IBR_EN_MASTER]
    |-> s_pend_set and !q.req)
    else $error("disabled error event mishandled");
  a_temp_pending: assert property (@(posedge core_clk) disable iff (srst)
    ((temp_event & ~q.tstat & q.ien[3:0]) != 4'h0) |=> s_pend_set)
    else $error("enabled temperature event lost");
  a_done_clears: assert property (@(posedge core_clk) disable iff (srst)
    done_evt && error_event == 2'h0 && temp_event == 4'h0
    |=> !q.pending && q.nibble == `IBR_NIB_NONE)
    else $error("completed payload left pending set");
  a_status_latched: assert property (@(posedge core_clk) disable iff (srst)
    q.estat[0] && !(wr && paddr == `IBR_REG_ERROR && pwdata[0])
    && !(wr && paddr == `IBR_REG_CTRL) |=> q.estat[0])
    else $error("error status dropped without a clear");

  // checks in the link domain
  sequence s_nack_seen;
    l.state == L_ACK && scl_rise && sda_nf;
  endsequence
  a_nack_no_data: assert property (@(posedge link_clk) disable iff (lrst)
    s_nack_seen |=> l.state == L_WSTOP ##1 !l.sda_oe)
    else $error("payload started after NACK");
  a_lost_release: assert property (@(posedge link_clk) disable iff (lrst)
    l.state == L_ADDR && scl_rise && l.shreg[7] && !sda_nf
    |=> !l.sda_oe && l.state == L_WSTOP)
    else $error("SDA still driven after lost arbitration");
  a_idle_issue: assert property (@(posedge link_clk) disable iff (lrst)
    l.state == L_IDLE && l.req_s[1] && avail && !start_c
    |-> ##[1:ISSUE_CYC] (l.sda_oe && !l.sda_out))
    else $error("idle-bus request not issued in time");
  a_addr_on_fall: assert property (@(posedge link_clk) disable iff (lrst)
    l.state == L_ADDR && $changed(l.sda_oe) |-> $past(scl_fall))
    else $error("address bit changed away from SCL fall");
  a_abort_keep: assert property (@(posedge link_clk) disable iff (lrst)
    l.state == L_TBIT && scl_rise && !sda_nf && l.byte_idx != last_idx
    |=> $stable(l.done_tgl))
    else $error("aborted payload reported complete");
endmodule
`default_nettype wire

// *** ibr_consts.svh ***
// register offsets, field positions, reset values and timing for the requester
`ifndef IBR_CONSTS_SVH
`define IBR_CONSTS_SVH
`define IBR_REG_ENABLE 8'h00
`define IBR_REG_PENDING 8'h04
`define IBR_REG_TEMP 8'h08
`define IBR_REG_ERROR 8'h0c
`define IBR_REG_CTRL 8'h10
`define IBR_EN_MASTER 4
`define IBR_PEND_FLAG 7
`define IBR_CTRL_I3C 0
`define IBR_CTRL_PEC 1
`define IBR_CTRL_GCLR 2
`define IBR_CTRL_LCODE_LSB 8
`define IBR_CTRL_HCODE_LSB 12
`define IBR_EN_RESET 5'h00
`define IBR_NIB_NONE 4'h0
`define IBR_NIB_EVENT 4'h1
`define IBR_MDB 8'h00
`define IBR_CRC_POLY 8'h07
`define IBR_CRC_SEED 8'h00
`define IBR_LINK_PERIOD_NS 15
`define IBR_AVAL_NS 1000
`define IBR_ISSUE_NS 100
`endif

// *** ibr_pkg.sv ***
// types shared by the in-band interrupt requester
`default_nettype none
package ibr_pkg;
  typedef enum logic [3:0] {
    L_IDLE, L_REQ, L_WSTART, L_ADDR, L_ACK, L_PUSH, L_DATA, L_TBIT, L_WSTOP
  } ibr_lstate_t;
  typedef struct packed {
    logic [4:0] ien;
    logic i3c;
    logic packet_check_byte;
    logic [3:0] lcode;
    logic [2:0] hcode;
    logic [3:0] tstat;
    logic [1:0] estat;
    logic pending;
    logic [3:0] nibble;
    logic req;
    logic [7:0] snap_temp;
    logic [7:0] snap_err;
    logic snap_pec;
    logic [1:0] busy_s;
    logic [2:0] done_s;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ibr_core_t;
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [1:0] req_s;
    ibr_lstate_t state;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic [7:0] crc;
    logic [15:0] idle_cnt;
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic done_tgl;
  } ibr_link_t;
endpackage
`default_nettype wire

// *** ibr_host_model.sv ***
// behavioural bus host: clocks SCL and answers in-band interrupts
`default_nettype none
module ibr_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles high, sda released to its pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one byte msb first; the device moves sda some time after each fall
  task automatic rx_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      #200 scl = 1'b1;
      v[i] = sda;
      #200 scl = 1'b0;
    end
  endtask

  // stop: sda rises while scl is high, entered with scl low
  task automatic stop_bus;
    sda_low = 1'b1;
    #200 scl = 1'b1;
    #200 sda_low = 1'b0;
    #400;
  endtask

  // wait for a request, clock the address, then ack or nack;
  // full=0 stops at the t bit of byte n, which the device must see as abort
  task automatic take(input bit ack, input int n, input bit full,
                      output logic [7:0] adr, output logic [31:0] pay,
                      output bit got);
    int k;
    logic [7:0] b;
    got = 0;
    pay = 32'h0;
    adr = 8'h00;
    for (k = 0; k < 5000 && sda !== 1'b0; k++) #10;
    if (sda !== 1'b0) return;
    got = 1;
    #100 scl = 1'b0;
    rx_byte(adr);
    sda_low = ack;
    #200 scl = 1'b1;
    #200 scl = 1'b0;
    #50 sda_low = 1'b0;
    if (!ack) begin
      #150 stop_bus;
      return;
    end
    for (k = 0; k < n; k++) begin
      rx_byte(b);
      pay = {pay[23:0], b};
      if (k == n - 1 && !full) begin
        // hold the released t bit low through its rise, then stop
        #100 sda_low = 1'b1;
        #100 scl = 1'b1;
        #200 sda_low = 1'b0;
        #400;
        return;
      end
      #200 scl = 1'b1;
      #200 scl = 1'b0;
    end
    #200 stop_bus;
  endtask
endmodule
`default_nettype wire

// *** ibr_requester_bench.sv ***
// self-checking bench for the in-band interrupt requester
`default_nettype none
`include "ibr_consts.svh"
module ibr_requester_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ADDR = {4'h3, 3'h7, 1'b1};
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, perr, sda_out, sda_oe, scl, sda_low, sda;
  logic [3:0] temp_event = 4'h0;
  logic [1:0] error_event = 2'h0;
  int err_count = 0;
  int n_compared = 0;

  // wire level: host pull-down wins, else device drive, else pull-up
  assign sda = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

  ibr_requester #(.LCODE_DEFAULT(4'h3), .HCODE_DEFAULT(3'h7)) uut (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .temp_event(temp_event),
    .error_event(error_event), .link_clk(link_clk), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));

  ibr_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));

  // two unrelated clocks: 25 ns core, 15 ns link with an odd offset
  initial forever #12.5 core_clk = ~core_clk;
  initial begin
    #3.1;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED @%0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // apb transfer held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string m);
    apb(1'b0, a, 32'h0, rd);
    chk(rd, e, m);
  endtask

  // crc-8, poly x8+x2+x+1, zero seed, over address and payload bytes
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // short event pulse; status bits latch it
  task automatic pulse(input logic [3:0] tv, input logic [1:0] ev);
    @(posedge core_clk);
    temp_event <= tv;
    error_event <= ev;
    repeat (3) @(posedge core_clk);
    temp_event <= 4'h0;
    error_event <= 2'h0;
  endtask

  // 5 us is well past the idle interval, so a request would show
  task automatic no_req(input string m);
    logic seen;
    seen = 1'b0;
    repeat (200) @(posedge core_clk) if (sda_oe !== 1'b0) seen = 1'b1;
    chk(seen, 1'b0, m);
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_reset;
    rdchk(`IBR_REG_ENABLE, 32'h0, "enable reset");
    rdchk(`IBR_REG_PENDING, 32'h0, "pending reset");
    apb(1'b0, 8'h20, 32'h0, rd);
    chk(perr, 1'b1, "unmapped error");
    $display("test reset done");
  endtask

  task automatic t_quiet(input string n, input logic [31:0] c,
                         input logic [31:0] e, input logic [3:0] tv,
                         input logic [1:0] ev);
    wr(`IBR_REG_CTRL, c);
    wr(`IBR_REG_ENABLE, e);
    pulse(tv, ev);
    no_req("request issued");
    rdchk(`IBR_REG_PENDING, 32'h81, "pending set");
    wr(`IBR_REG_TEMP, 32'hf);
    wr(`IBR_REG_ERROR, 32'h3);
    rdchk(`IBR_REG_PENDING, 32'h0, "pending cleared");
    $display("test %s done", n);
  endtask

  task automatic t_ibi;
    logic [7:0] a;
    logic [31:0] p;
    bit g;
    wr(`IBR_REG_CTRL, 32'h7303);
    wr(`IBR_REG_ENABLE, 32'h14);
    pulse(4'h4, 2'h1);
    host.take(1'b0, 0, 1'b1, a, p, g);
    chk(g, 1'b1, "no request");
    chk(a, ADDR, "address byte");
    rdchk(`IBR_REG_PENDING, 32'h81, "pending after nack");
    host.take(1'b1, 1, 1'b0, a, p, g);
    chk(g, 1'b1, "no retry");
    chk(p, 32'h0, "mdb");
    rdchk(`IBR_REG_PENDING, 32'h81, "pending after abort");
    host.take(1'b1, 4, 1'b1, a, p, g);
    chk(a, ADDR, "address on idle bus");
    chk(p, {24'h000401, crc8({ADDR, 24'h000401})}, "payload");
    repeat (10) @(posedge core_clk);
    rdchk(`IBR_REG_PENDING, 32'h0, "pending after payload");
    rdchk(`IBR_REG_TEMP, 32'h4, "temp status kept");
    rdchk(`IBR_REG_ERROR, 32'h1, "error status kept");
    no_req("request repeated");
    wr(`IBR_REG_TEMP, 32'hf);
    wr(`IBR_REG_ERROR, 32'h3);
    rdchk(`IBR_REG_TEMP, 32'h0, "temp status clear");
    $display("test interrupt transfer done");
  endtask

  // watchdog: the whole run needs well under 300 us
  initial begin
    #1000000;
    err_count++;
    $display("CHECK FAILED @%0t: watchdog expired", $time);
    end_sim;
  end

  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    t_reset;
    t_quiet("i2c mode", 32'h7300, 32'h1f, 4'h1, 2'h1);
    t_quiet("error off", 32'h7301, 32'h0f, 4'h0, 2'h2);
    t_quiet("master off", 32'h7301, 32'h01, 4'h1, 2'h0);
    t_ibi;
    end_sim;
  end
endmodule
`default_nettype wire
